// File: verilog/wdr_top.sv
// Purpose: watchdog downcounter with software reset and stop handling
// Assumes: APB slave, option straps steady around reset release
// Notes: reset pin is open-drain, oe_n low while pulling low
// Functional notes
// (R1) decrement stored count every 3072 clocks
// (R2) timeout programmable in 64 equal steps
// (R3) hardware option: active from reset, forced
// (R4) hardware option: activation bit read meaningless
// (R5) software option: set once, stays active
// (R6) active and count top bit zero: pulse reset
// (R7) write clearing top bit while active resets
// (R8) software refreshes with FEh down to 02h
// (R9) software writes active, top bit, count
// (R10) timeouts scale with 3072-clock period
// (R11) inactive: STOP enters stop; WAIT no effect
// (R12) active, no external control: STOP acts WAIT
// (R13) external control: NMI low WAIT, high freezes
// (R14) leaving stop resumes from held count
// (R15) inactive software option: free 7-bit timer
// (R16) count bits reversed in register
// (R17) software reads timer twice to validate
// (R18) software timer checks activation, forces reset
// (R19) timer decrements once every period
// (R20) activation bit 0, top bit 1, T0 bit 7
// (R21) register resets to FEh
// (R22) inactive: top bit is timer MSB only
// (R23) write reloads count and restarts interval
//
// Our own choices: the register offsets and register access over APB.
`include "wdr_cfg.svh"
`default_nettype none
module wdr_top #(
  parameter int TICK_CYCLES = `WDR_TICK_CYCLES,
  parameter int PULSE_CYCLES = `WDR_RST_PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`WDR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic activation_option,
  input wire logic external_stop_control_option,
  input wire logic nmi_pin,
  input wire logic stop_instr,
  input wire logic wait_instr,
  input wire logic wake_irq,
  output var wdr_pkg::wdr_pwr_t pwr_state,
  output logic reset_pin_out,
  output logic reset_pin_oe_n
);

  // register layout mapping, used on read and write
  function automatic logic [7:0] cnt_to_reg(input logic [6:0] c, input logic act);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 6; i++)
    begin
      r[7-i] = c[i]; // (R16) (R20)
    end
    r[`WDR_SOFTRST_BIT] = c[6]; // (R20)
    r[`WDR_ACT_BIT] = act; // (R20)
    return r;
  endfunction

  function automatic logic [6:0] reg_to_cnt(input logic [7:0] r);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 6; i++)
    begin
      c[i] = r[7-i]; // (R16)
    end
    c[6] = r[`WDR_SOFTRST_BIT];
    return c;
  endfunction

  function automatic logic addr_hit(input logic [`WDR_ADDR_W-1:0] a,
                                    input logic [`WDR_ADDR_W-1:0] b);
    return a == b;
  endfunction

  // option straps taken after reset release
  logic opt_taken_q;
  wdr_pkg::wdr_opt_t opt_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      opt_taken_q <= 1'b0;
      opt_q <= '0;
    end
    else if (!opt_taken_q)
    begin
      opt_taken_q <= 1'b1;
      opt_q.hw_act <= activation_option;
      opt_q.ext_stop <= external_stop_control_option;
    end
  end

  // nmi pin synchroniser
  logic nmi_meta_q;
  logic nmi_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      nmi_meta_q <= 1'b0;
      nmi_q <= 1'b0;
    end
    else
    begin
      nmi_meta_q <= nmi_pin;
      nmi_q <= nmi_meta_q;
    end
  end

  // apb decode
  logic setup_ph;
  logic access_ph;
  logic hit_ctrl;
  logic hit_stat;
  logic ctrl_wr;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign hit_ctrl = addr_hit(paddr, `WDR_CTRL_ADDR);
  assign hit_stat = addr_hit(paddr, `WDR_STAT_ADDR);
  assign ctrl_wr = access_ph && pwrite && hit_ctrl && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = access_ph && !(hit_ctrl || (hit_stat && !pwrite));

  // activation state
  logic act_q;
  logic act_eff;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      act_q <= 1'b0; // (R5)
    end
    else if (opt_taken_q ? opt_q.hw_act : activation_option)
    begin
      act_q <= 1'b1; // (R3)
    end
    else if (ctrl_wr && pwdata[`WDR_ACT_BIT])
    begin
      act_q <= 1'b1; // (R5)
    end
  end

  // hardware option counts as active from the first cycle
  assign act_eff = act_q || (!opt_taken_q && activation_option); // (R3)

  // power mode control
  wdr_pkg::wdr_pmode_t pmode_q;
  logic frozen;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pmode_q <= wdr_pkg::WDR_RUN;
    end
    else
    begin
      case (pmode_q)
        wdr_pkg::WDR_RUN:
        begin
          if (stop_instr)
          begin
            if (!act_eff)
            begin
              pmode_q <= wdr_pkg::WDR_STOP; // (R11)
            end
            else if (!opt_q.ext_stop)
            begin
              pmode_q <= wdr_pkg::WDR_WAIT; // (R12)
            end
            else if (nmi_q)
            begin
              pmode_q <= wdr_pkg::WDR_STOP; // (R13)
            end
            else
            begin
              pmode_q <= wdr_pkg::WDR_WAIT; // (R13)
            end
          end
          else if (wait_instr)
          begin
            pmode_q <= wdr_pkg::WDR_WAIT;
          end
        end
        wdr_pkg::WDR_WAIT:
        begin
          if (wake_irq)
          begin
            pmode_q <= wdr_pkg::WDR_RUN;
          end
        end
        wdr_pkg::WDR_STOP:
        begin
          if (wake_irq)
          begin
            pmode_q <= wdr_pkg::WDR_RUN; // (R14)
          end
        end
        default:
        begin
          pmode_q <= wdr_pkg::WDR_RUN;
        end
      endcase
    end
  end

  // wait leaves the counter running, stop holds it
  assign frozen = (pmode_q == wdr_pkg::WDR_STOP); // (R11) (R13)

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pwr_state <= '0;
    end
    else
    begin
      pwr_state.stop_mode <= (pmode_q == wdr_pkg::WDR_STOP);
      pwr_state.wait_mode <= (pmode_q == wdr_pkg::WDR_WAIT);
    end
  end

  // decrement interval
  logic tick;

  wdr_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(ctrl_wr), // (R23)
    .run(!frozen), // (R14)
    .tick(tick)
  );

  // 7-bit downcounter, top bit is the soft reset bit
  logic [6:0] cnt_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= `WDR_CNT_RESET; // (R21)
    end
    else if (ctrl_wr)
    begin
      cnt_q <= reg_to_cnt(pwdata[7:0]); // (R2) (R23)
    end
    else if (tick)
    begin
      cnt_q <= cnt_q - 7'h01; // (R1) (R15) (R19) (R10)
    end
  end

  // reset request and pin pulse
  logic rst_req;
  logic rst_busy;

  assign rst_req = act_eff && !cnt_q[6]; // (R6) (R7) (R22)

  wdr_rst_pulse #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(rst_req), // (R6)
    .busy(rst_busy)
  );

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reset_pin_oe_n <= 1'b1;
    end
    else
    begin
      reset_pin_oe_n <= !rst_busy; // (R6)
    end
  end

  assign reset_pin_out = 1'b0;

  // status word
  logic [7:0] stat_word;

  always_comb
  begin
    stat_word = 8'h00;
    stat_word[`WDR_STAT_HWOPT_BIT] = opt_q.hw_act;
    stat_word[`WDR_STAT_EXTOPT_BIT] = opt_q.ext_stop;
    stat_word[`WDR_STAT_STOP_BIT] = (pmode_q == wdr_pkg::WDR_STOP);
    stat_word[`WDR_STAT_WAIT_BIT] = (pmode_q == wdr_pkg::WDR_WAIT);
    stat_word[`WDR_STAT_NMI_BIT] = nmi_q;
    stat_word[`WDR_STAT_ACT_BIT] = act_eff;
    stat_word[`WDR_STAT_RST_BIT] = rst_busy;
  end

  // read data captured in setup phase
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (setup_ph && !pwrite)
    begin
      if (hit_ctrl)
      begin
        prdata <= {24'h00_0000, cnt_to_reg(cnt_q, act_eff)}; // (R4) (R16) (R15)
      end
      else if (hit_stat)
      begin
        prdata <= {24'h00_0000, stat_word};
      end
      else
      begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule // wdr_top
`default_nettype wire

// File: verilog/wdr_cfg.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 50 MHz ref_clk, APB with 32-bit data
// Notes: byte address of a register is four times its index
`ifndef WDR_CFG_SVH
`define WDR_CFG_SVH

`define WDR_CLK_MHZ 50
`define WDR_CTRL_IDX 8'hd8
`define WDR_STAT_IDX 8'hd9
`define WDR_CTRL_ADDR 12'h360
`define WDR_STAT_ADDR 12'h364
`define WDR_ADDR_W 12
`define WDR_CTRL_RESET 8'hfe
`define WDR_CNT_RESET 7'h7f
`define WDR_ACT_BIT 0
`define WDR_SOFTRST_BIT 1
`define WDR_STAT_HWOPT_BIT 0
`define WDR_STAT_EXTOPT_BIT 1
`define WDR_STAT_STOP_BIT 2
`define WDR_STAT_WAIT_BIT 3
`define WDR_STAT_NMI_BIT 4
`define WDR_STAT_ACT_BIT 5
`define WDR_STAT_RST_BIT 6
`define WDR_TICK_CYCLES 3072
`define WDR_RST_PULSE_NS 500
`define WDR_RST_PULSE_CYC ((`WDR_RST_PULSE_NS * `WDR_CLK_MHZ) / 1000)

`endif

// File: verilog/wdr_pkg.sv
// Purpose: shared types of the watchdog
// Assumes: nothing
// Notes: constants live in wdr_cfg.svh
`default_nettype none
package wdr_pkg;

  typedef enum logic [2:0] {
    WDR_RUN  = 3'b001,
    WDR_WAIT = 3'b010,
    WDR_STOP = 3'b100
  } wdr_pmode_t;

  typedef struct packed {
    logic hw_act;
    logic ext_stop;
  } wdr_opt_t;

  typedef struct packed {
    logic stop_mode;
    logic wait_mode;
  } wdr_pwr_t;

endpackage
`default_nettype wire

// File: verilog/wdr_tick_div.sv
// Purpose: divider giving one enable pulse per decrement period
// Assumes: clr restarts the interval, run low holds it
// Notes: tick is a one-cycle pulse
`default_nettype none
module wdr_tick_div #(
  parameter int TICK_CYCLES = 3072
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic run,
  output logic tick
);
  localparam int W = $clog2(TICK_CYCLES);
  localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

  logic [W-1:0] cnt_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
    end
    else if (clr)
    begin
      cnt_q <= '0;
    end
    else if (run)
    begin
      if (cnt_q == LAST)
      begin
        cnt_q <= '0;
      end
      else
      begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

  assign tick = run && !clr && (cnt_q == LAST);
endmodule // wdr_tick_div
`default_nettype wire

// File: verilog/wdr_rst_pulse.sv
// Purpose: stretch a reset request into a fixed-length pin pulse
// Assumes: start is a one-cycle pulse or a level
// Notes: requests during a pulse are ignored
`default_nettype none
module wdr_rst_pulse #(
  parameter int PULSE_CYCLES = 25
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy
);
  localparam int W = $clog2(PULSE_CYCLES + 1);

  logic [W-1:0] left_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      left_q <= '0;
    end
    else if (left_q != '0)
    begin
      left_q <= left_q - W'(1);
    end
    else if (start)
    begin
      left_q <= W'(PULSE_CYCLES);
    end
  end

  assign busy = (left_q != '0);
endmodule // wdr_rst_pulse
`default_nettype wire

// File: tb/wdr_assertions.sv
// Purpose: port checks of the watchdog
// Assumes: bench runs with a three-cycle reset pulse
// Notes: bound to wdr_top
`default_nettype none
module wdr_assertions #(
  parameter int TICK_CYCLES = 8,
  parameter int PULSE_CYCLES = 3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic stop_instr,
  input wire logic wait_instr,
  input wire logic wake_irq,
  input wire wdr_pkg::wdr_pwr_t pwr_state,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  pulse_len_a: assert property (
    $fell(reset_pin_oe_n) |-> (!reset_pin_oe_n)[*3]) else $error("reset pulse short");
  soft_reset_a: assert property (
    psel && penable && pwrite && pstrb[0] && paddr == 12'h360 && pwdata[1:0] == 2'h1
    |-> ##[1:3] !reset_pin_oe_n) else $error("no reset after soft reset write");
  pin_level_a: assert property (reset_pin_out == 1'b0)
    else $error("reset pin drives high");
  stop_entry_a: assert property (
    stop_instr && !wake_irq |-> ##[1:2] (pwr_state.stop_mode || pwr_state.wait_mode))
    else $error("stop request ignored");
  wait_entry_a: assert property (
    wait_instr && !wake_irq && !pwr_state.stop_mode |-> ##[1:2] pwr_state.wait_mode)
    else $error("wait request ignored");
  wake_exit_a: assert property (wake_irq |-> ##[1:2] pwr_state == 2'h0)
    else $error("no return to run");
  mode_excl_a: assert property (!(pwr_state.stop_mode && pwr_state.wait_mode))
    else $error("stop and wait together");
  upper_zero_a: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  unmapped_err_a: assert property (
    psel && penable && paddr != 12'h360 && paddr != 12'h364 |-> pslverr)
    else $error("no error on unmapped access");
  status_wr_err_a: assert property (
    psel && penable && pwrite && paddr == 12'h364 |-> pslverr)
    else $error("no error on status write");
endmodule // wdr_assertions

bind wdr_top wdr_assertions #(.TICK_CYCLES(TICK_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
  .stop_instr(stop_instr), .wait_instr(wait_instr), .wake_irq(wake_irq),
  .pwr_state(pwr_state), .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n));
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench of the watchdog
// Assumes: short tick of 8 and pulse of 3 cycles
// Notes: expected counts derived from register layout
`default_nettype none
`define CHK(n, x, g) begin samples_checked++; if ((g) !== (x)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, x, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic hw = 0, ext = 0, nmi = 0, stp = 0, wt = 0, wake = 0, pready, pslverr, pin, oe_n;
  logic [7:0] r, r1;
  logic [6:0] c, d;
  wdr_pkg::wdr_pwr_t pwr;
  int fails = 0, samples_checked = 0, low_cnt = 0, l0, k;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (oe_n === 1'b0) low_cnt <= low_cnt + 1;
  wdr_top #(.TICK_CYCLES(8), .PULSE_CYCLES(3)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .activation_option(hw), .external_stop_control_option(ext), .nmi_pin(nmi),
    .stop_instr(stp), .wait_instr(wt), .wake_irq(wake), .pwr_state(pwr),
    .reset_pin_out(pin), .reset_pin_oe_n(oe_n));
  function automatic logic [6:0] cnt_of(input logic [7:0] b);
    return {b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
  endfunction
  function automatic logic [7:0] reg_of(input logic [6:0] v, input logic a);
    return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], a};
  endfunction
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int s);
    @(posedge ref_clk);
    stp <= (s == 0);
    wt <= (s == 1);
    wake <= (s == 2);
    @(posedge ref_clk);
    stp <= 1'b0;
    wt <= 1'b0;
    wake <= 1'b0;
    tk(2);
  endtask
  task automatic do_reset(input logic h, input logic x);
    rst <= 1'b1;
    hw <= h;
    ext <= x;
    tk(5);
    rst <= 1'b0;
  endtask
  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    tk(20000);
    fails++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h5419c3d0));
    do_reset(1'b0, 1'b0);
    apb(1'b0, 12'h360, 8'h0);
    `CHK("ctrl reset", 8'hfe, r)
    apb(1'b0, 12'h100, 8'h0);
    `CHK("unmapped", 9'h100, {e, r})
    for (int i = 0; i < 4; i++)
    begin
      c = {1'b1, 6'($urandom)};
      k = 1 + i % 3;
      apb(1'b1, 12'h360, reg_of(c, 1'b0));
      apb(1'b0, 12'h360, 8'h0);
      `CHK("readback", reg_of(c, 1'b0), r)
      tk(8 * k);
      apb(1'b0, 12'h360, 8'h0);
      r1 = r;
      apb(1'b0, 12'h360, 8'h0);
      `CHK("read twice", r1, r)
      d = c - cnt_of(r);
      `CHK("decrement", 1'b1, d >= k - 1 && d <= k)
    end
    apb(1'b1, 12'h360, 8'hfc);
    l0 = low_cnt;
    tk(40);
    `CHK("no pulse inactive", l0, low_cnt)
    pulse(0);
    `CHK("stop inactive", 2'h2, pwr)
    pulse(2);
    pulse(1);
    `CHK("wait", 2'h1, pwr)
    pulse(2);
    apb(1'b1, 12'h360, 8'hff);
    apb(1'b1, 12'h360, 8'hfe);
    apb(1'b0, 12'h360, 8'h0);
    `CHK("stays active", 1'b1, r[0])
    pulse(0);
    `CHK("stop as wait", 2'h1, pwr)
    pulse(2);
    apb(1'b1, 12'h360, 8'hfd);
    tk(4);
    `CHK("soft reset", 1'b1, low_cnt > l0)
    do_reset(1'b1, 1'b0);
    apb(1'b1, 12'h360, 8'hfe);
    apb(1'b0, 12'h360, 8'h0);
    `CHK("forced active", 1'b1, r[0])
    l0 = low_cnt;
    tk(495);
    `CHK("before timeout", l0, low_cnt)
    tk(35);
    `CHK("timeout pulse", 1'b1, low_cnt > l0)
    do_reset(1'b1, 1'b1);
    nmi <= 1'b1;
    apb(1'b1, 12'h360, 8'hff);
    pulse(0);
    `CHK("stop nmi high", 2'h2, pwr)
    apb(1'b0, 12'h364, 8'h0);
    `CHK("status", 9'h037, {e, r})
    apb(1'b1, 12'h364, 8'h0);
    `CHK("status write", 1'b1, e)
    apb(1'b0, 12'h360, 8'h0);
    r1 = r;
    tk(32);
    apb(1'b0, 12'h360, 8'h0);
    `CHK("frozen", r1, r)
    pulse(2);
    tk(24);
    apb(1'b0, 12'h360, 8'h0);
    d = cnt_of(r1) - cnt_of(r);
    `CHK("resumes", 1'b1, d >= 2 && d <= 4)
    nmi <= 1'b0;
    tk(4);
    pulse(0);
    `CHK("stop nmi low", 2'h1, pwr)
    pulse(2);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
